// *** rtl/serial_pkg.sv ***
// package: constants and state types for the two-channel serial port
`default_nettype none
package serial_pkg;

    // ==========================================================
    // clock and baud timing
    localparam int CLK_HZ = 250_000_000;
    localparam int BAUD_DEF = 9600;
    localparam int BAUD_LO = 1200;
    localparam int BAUD_HI = 921600;
    localparam int DW = 18;
    localparam logic [DW-1:0] DIV_RST = DW'(CLK_HZ / BAUD_DEF);
    localparam logic [DW-1:0] DIV_MAX = DW'(CLK_HZ / BAUD_LO);
    localparam logic [DW-1:0] DIV_MIN = DW'(CLK_HZ / BAUD_HI);

    // ==========================================================
    // queues
    localparam int NCH = 2;
    localparam int RX_AW = 10;
    localparam int TX_AW = 8;
    localparam logic [RX_AW:0] RX_LIM_RST = 11'h100;
    localparam logic [RX_AW:0] RX_LIM_MAX = 11'h400;
    localparam logic [RX_AW:0] RX_THR_RST = 11'h001;
    localparam logic [TX_AW:0] TX_CAP = 9'h100;

    // ==========================================================
    // register map
    localparam int AW = 8;
    localparam int CH_SEL = 5;
    localparam logic [CH_SEL-1:0] OFS_CTRL = 5'h00;
    localparam logic [CH_SEL-1:0] OFS_BAUD = 5'h04;
    localparam logic [CH_SEL-1:0] OFS_RXCFG = 5'h08;
    localparam logic [CH_SEL-1:0] OFS_STAT = 5'h0c;
    localparam logic [CH_SEL-1:0] OFS_TXD = 5'h10;
    localparam logic [CH_SEL-1:0] OFS_RXD = 5'h14;
    localparam logic [AW-1:0] OFS_IRQ_ST = 8'h40;
    localparam logic [AW-1:0] OFS_IRQ_CLR = 8'h44;
    localparam logic [AW-1:0] OFS_IRQ_EN = 8'h48;

    // ==========================================================
    // field positions
    localparam int CTL_OPEN = 0;
    localparam int CTL_PAR = 1;
    localparam int CTL_ODD = 2;
    localparam int CTL_TWO = 3;
    localparam int CTL_SEVEN = 4;
    localparam int CTL_INV = 5;
    localparam int CTL_W = 6;
    localparam int RXCFG_THR = 16;
    localparam int ST_FREE = 16;
    localparam int ST_ACTIVE = 28;
    localparam int ST_BUSY = 29;
    localparam int EV_RXTHR = 0;
    localparam int EV_PERR = 1;
    localparam int EV_OVF = 2;
    localparam int EV_TXDONE = 3;
    localparam int EV_N = 4;
    localparam int IRQ_W = NCH * EV_N;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // state types
    typedef enum logic {LN_IDLE, LN_RUN} line_st_t;

    typedef struct packed {
        logic [CTL_W-1:0] ctl;
        logic active;
        logic [DW-1:0] div;
        logic [RX_AW:0] rx_lim;
        logic [RX_AW:0] rx_thr;
        logic [RX_AW-1:0] rx_wp;
        logic [RX_AW-1:0] rx_rp;
        logic [RX_AW:0] rx_cnt;
        logic [TX_AW-1:0] tx_wp;
        logic [TX_AW-1:0] tx_rp;
        logic [TX_AW:0] tx_cnt;
        line_st_t tx_st;
        logic [DW-1:0] tx_tmr;
        logic [3:0] tx_left;
        logic [11:0] tx_fr;
        logic txd;
        line_st_t rx_st;
        logic [DW-1:0] rx_tmr;
        logic [3:0] rx_idx;
        logic [11:0] rx_sh;
        logic [1:0] rx_sync;
    } chan_t;

    typedef struct packed {
        logic aw_ok;
        logic w_ok;
        logic [AW-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [IRQ_W-1:0] irq_st;
        logic [IRQ_W-1:0] irq_en;
        logic irq;
        chan_t [NCH-1:0] ch;
    } state_t;

endpackage
`default_nettype wire

// *** rtl/char_ram.sv ***
// character queue storage with registered read port
`default_nettype none
module char_ram #(
    parameter int W = 8,
    parameter int AW = 8
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata
);
    logic [W-1:0] mem [2**AW];

    // ==========================================================
    // write-first bypass so a push into an empty queue reads back at once
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= (we && waddr == raddr) ? wdata : mem[raddr];
    end
endmodule
`default_nettype wire

// *** rtl/dual_channel_async_serial_port.sv ***
// top: two-channel asynchronous serial port behind axi4-lite registers
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`default_nettype none
// Function
// - two independent channels, each with its own receive, transmit and settings.
// - line idles high, start bit low, data one high, stop bit high.
// - after reset a channel runs 9600 baud, eight data bits, no parity, one stop.
// - baud is programmable over the range 1200 to 921600 bits per second.
// - receive queue size is programmable in bytes and defaults to 256.
// - transmit queue holds exactly 256 bytes and cannot be resized.
// - a receive event fires when unread characters reach the threshold.
// - two-stop option appends two stop bits to every sent character.
// - even parity adds a parity bit after the data, seven or eight bits.
// - odd parity adds a parity bit after the data, seven or eight bits.
// - seven-bit option carries seven data bits instead of eight.
// - inversion option inverts the transmit output and the receive input.
// - tx line is driven by this block, rx line is driven by the far party.
// - a character arriving to a full receive queue evicts the oldest one.
// - closing waits for the transmit queue to drain, then flushes and cancels.
module dual_channel_async_serial_port (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [serial_pkg::AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [serial_pkg::AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic irq,
    input wire logic first_serial_channel_rx,
    output logic first_serial_channel_tx,
    input wire logic second_serial_channel_rx,
    output logic second_serial_channel_tx
);
    import serial_pkg::*;

    state_t s_q;
    state_t s_d;
    chan_t o;
    logic [NCH-1:0] rx_pin;
    logic [NCH-1:0] rx_push;
    logic [NCH-1:0] rx_pop;
    logic [NCH-1:0] tx_push;
    logic [NCH-1:0] tx_pop;
    logic [NCH-1:0] tx_done;
    logic [NCH-1:0][7:0] rx_wd;
    logic [NCH-1:0][7:0] rx_q;
    logic [NCH-1:0][7:0] tx_q;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    logic [31:0] wm;
    logic wc;
    logic rc;
    logic rxl;
    logic drop;
    logic pbit;
    logic [3:0] nbits;
    logic [3:0] last;

    // ==========================================================
    // helpers
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [DW-1:0] clamp_div(input logic [31:0] v);
        if (v > 32'(DIV_MAX)) begin
            return DIV_MAX;
        end
        if (v < 32'(DIV_MIN)) begin
            return DIV_MIN;
        end
        return v[DW-1:0];
    endfunction

    function automatic logic mapped(input logic [AW-1:0] a);
        return a == OFS_IRQ_ST || a == OFS_IRQ_CLR || a == OFS_IRQ_EN ||
               (a[AW-1:CH_SEL+1] == '0 && a[1:0] == 2'h0 && a[CH_SEL-1:0] <= OFS_RXD);
    endfunction

    // frame bits in send order: start, data lsb first, parity, stops
    function automatic logic [11:0] mkframe(input logic [7:0] d, input logic [CTL_W-1:0] ctl);
        logic [11:0] f;
        logic p;
        f = 12'hfff;
        f[0] = 1'b0;
        p = (ctl[CTL_SEVEN] ? ^d[6:0] : ^d) ^ ctl[CTL_ODD];
        if (ctl[CTL_SEVEN]) begin
            f[7:1] = d[6:0];
            f[8] = ctl[CTL_PAR] ? p : 1'b1;
        end else begin
            f[8:1] = d;
            f[9] = ctl[CTL_PAR] ? p : 1'b1;
        end
        return f;
    endfunction

    function automatic logic [31:0] regval(input logic [AW-1:0] a);
        logic [31:0] v;
        chan_t ch;
        v = '0;
        ch = s_q.ch[a[CH_SEL]];
        if (a == OFS_IRQ_ST) begin
            v[IRQ_W-1:0] = s_q.irq_st;
        end else if (a == OFS_IRQ_EN) begin
            v[IRQ_W-1:0] = s_q.irq_en;
        end else if (a[AW-1:CH_SEL+1] == '0) begin
            case (a[CH_SEL-1:0])
                OFS_CTRL: v[CTL_W-1:0] = ch.ctl;
                OFS_BAUD: v[DW-1:0] = ch.div;
                OFS_RXCFG: begin
                    v[RX_AW:0] = ch.rx_lim;
                    v[RXCFG_THR +: RX_AW+1] = ch.rx_thr;
                end
                OFS_STAT: begin
                    v[RX_AW:0] = ch.rx_cnt;
                    v[ST_FREE +: TX_AW+1] = TX_CAP - ch.tx_cnt;
                    v[ST_ACTIVE] = ch.active;
                    v[ST_BUSY] = ch.tx_st == LN_RUN || ch.tx_cnt != '0;
                end
                OFS_RXD: v[7:0] = (ch.rx_cnt != '0) ? rx_q[a[CH_SEL]] : 8'h00;
                default: v = '0;
            endcase
        end
        return v;
    endfunction

    // ==========================================================
    // queue storage, one pair per channel
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        char_ram #(.W(8), .AW(RX_AW)) u_rxq (
            .clk(aclk),
            .we(rx_push[c]),
            .waddr(s_q.ch[c].rx_wp),
            .wdata(rx_wd[c]),
            .raddr(s_d.ch[c].rx_rp),
            .rdata(rx_q[c])
        );
        char_ram #(.W(8), .AW(TX_AW)) u_txq (
            .clk(aclk),
            .we(tx_push[c]),
            .waddr(s_q.ch[c].tx_wp),
            .wdata(s_q.wdata[7:0]),
            .raddr(s_d.ch[c].tx_rp),
            .rdata(tx_q[c])
        );
    end

    assign rx_pin = {second_serial_channel_rx, first_serial_channel_rx};

    // ==========================================================
    // next state
    always_comb begin
        s_d = s_q;
        o = s_q.ch[0];
        ev = '0;
        clr = '0;
        rx_push = '0;
        rx_pop = '0;
        tx_push = '0;
        tx_pop = '0;
        tx_done = '0;
        rx_wd = '0;
        rxl = 1'b1;
        drop = 1'b0;
        pbit = 1'b0;
        nbits = '0;
        last = '0;
        wm = wmerge(regval(s_q.awaddr), s_q.wdata, s_q.wstrb);
        wc = s_q.awaddr[CH_SEL];
        rc = araddr[CH_SEL];

        // bus write: address and data taken in either order
        if (awvalid && awready) begin
            s_d.aw_ok = 1'b1;
            s_d.awaddr = awaddr;
        end
        if (wvalid && wready) begin
            s_d.w_ok = 1'b1;
            s_d.wdata = wdata;
            s_d.wstrb = wstrb;
        end
        if (bvalid && bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.aw_ok && s_q.w_ok && !s_q.bvalid) begin
            s_d.aw_ok = 1'b0;
            s_d.w_ok = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = mapped(s_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
            if (s_q.awaddr == OFS_IRQ_CLR) begin
                clr = s_q.wdata[IRQ_W-1:0];
            end else if (s_q.awaddr == OFS_IRQ_EN) begin
                s_d.irq_en = wm[IRQ_W-1:0];
            end else if (s_q.awaddr[AW-1:CH_SEL+1] == '0) begin
                case (s_q.awaddr[CH_SEL-1:0])
                    OFS_CTRL: s_d.ch[wc].ctl = wm[CTL_W-1:0];
                    OFS_BAUD: s_d.ch[wc].div = clamp_div(wm);
                    OFS_RXCFG: begin
                        // zero or oversize depth falls back to the full store
                        if (wm[RX_AW:0] == '0 || wm[RX_AW:0] > RX_LIM_MAX) begin
                            s_d.ch[wc].rx_lim = RX_LIM_MAX;
                        end else begin
                            s_d.ch[wc].rx_lim = wm[RX_AW:0];
                        end
                        s_d.ch[wc].rx_thr = wm[RXCFG_THR +: RX_AW+1];
                    end
                    OFS_TXD: begin
                        // full queue or closing channel refuses the byte
                        if (s_q.ch[wc].tx_cnt == TX_CAP || !s_q.ch[wc].ctl[CTL_OPEN]) begin
                            s_d.bresp = RESP_SLVERR;
                        end else begin
                            tx_push[wc] = s_q.wstrb[0];
                        end
                    end
                    default: ;
                endcase
            end
        end

        // bus read: a read of the rx data register pops one character
        if (rvalid && rready) begin
            s_d.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = regval(araddr);
            s_d.rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            if (araddr[AW-1:CH_SEL+1] == '0 && araddr[CH_SEL-1:0] == OFS_RXD &&
                s_q.ch[rc].rx_cnt != '0) begin
                rx_pop[rc] = 1'b1;
            end
        end

        for (int c = 0; c < NCH; c++) begin
            o = s_q.ch[c];
            nbits = (o.ctl[CTL_SEVEN] ? 4'h8 : 4'h9) + {3'h0, o.ctl[CTL_PAR]} +
                    (o.ctl[CTL_TWO] ? 4'h2 : 4'h1);
            last = (o.ctl[CTL_SEVEN] ? 4'h8 : 4'h9) + {3'h0, o.ctl[CTL_PAR]};

            // transmitter
            unique case (o.tx_st)
                LN_IDLE: begin
                    if (o.active && o.tx_cnt != '0) begin
                        s_d.ch[c].tx_fr = mkframe(tx_q[c], o.ctl);
                        s_d.ch[c].tx_left = nbits;
                        s_d.ch[c].tx_tmr = o.div - 1'b1;
                        s_d.ch[c].tx_st = LN_RUN;
                        tx_pop[c] = 1'b1;
                    end
                end
                LN_RUN: begin
                    if (o.tx_tmr != '0) begin
                        s_d.ch[c].tx_tmr = o.tx_tmr - 1'b1;
                    end else if (o.tx_left == 4'h1) begin
                        s_d.ch[c].tx_st = LN_IDLE;
                        tx_done[c] = 1'b1;
                    end else begin
                        s_d.ch[c].tx_fr = {1'b1, o.tx_fr[11:1]};
                        s_d.ch[c].tx_left = o.tx_left - 1'b1;
                        s_d.ch[c].tx_tmr = o.div - 1'b1;
                    end
                end
            endcase
            s_d.ch[c].tx_wp = o.tx_wp + TX_AW'(tx_push[c]);
            s_d.ch[c].tx_rp = o.tx_rp + TX_AW'(tx_pop[c]);
            s_d.ch[c].tx_cnt = o.tx_cnt + (TX_AW+1)'(tx_push[c]) - (TX_AW+1)'(tx_pop[c]);
            if (tx_done[c] && s_d.ch[c].tx_cnt == '0) begin
                ev[c*EV_N + EV_TXDONE] = 1'b1;
            end
            // idle level high, flipped by the inversion option
            s_d.ch[c].txd = (s_d.ch[c].tx_st == LN_RUN ? s_d.ch[c].tx_fr[0] : 1'b1)
                            ^ o.ctl[CTL_INV];

            // receiver: two-stage sync, samples at mid-bit
            s_d.ch[c].rx_sync = {o.rx_sync[0], rx_pin[c]};
            rxl = o.rx_sync[1] ^ o.ctl[CTL_INV];
            unique case (o.rx_st)
                LN_IDLE: begin
                    if (o.active && !rxl) begin
                        s_d.ch[c].rx_tmr = o.div >> 1;
                        s_d.ch[c].rx_idx = '0;
                        s_d.ch[c].rx_st = LN_RUN;
                    end
                end
                LN_RUN: begin
                    if (o.rx_tmr != '0) begin
                        s_d.ch[c].rx_tmr = o.rx_tmr - 1'b1;
                    end else begin
                        s_d.ch[c].rx_tmr = o.div - 1'b1;
                        s_d.ch[c].rx_sh[o.rx_idx] = rxl;
                        s_d.ch[c].rx_idx = o.rx_idx + 1'b1;
                        // a start bit gone high by mid-bit was a glitch
                        if (o.rx_idx == '0 && rxl) begin
                            s_d.ch[c].rx_st = LN_IDLE;
                        end else if (o.rx_idx == last) begin
                            s_d.ch[c].rx_st = LN_IDLE;
                            rx_push[c] = 1'b1;
                        end
                    end
                end
            endcase
            rx_wd[c] = o.ctl[CTL_SEVEN] ? {1'b0, o.rx_sh[7:1]} : o.rx_sh[8:1];
            pbit = o.ctl[CTL_SEVEN] ? o.rx_sh[8] : o.rx_sh[9];
            if (rx_push[c] && o.ctl[CTL_PAR] &&
                (pbit != (^rx_wd[c] ^ o.ctl[CTL_ODD]))) begin
                ev[c*EV_N + EV_PERR] = 1'b1;
            end

            // full queue: the new character evicts the oldest
            drop = rx_push[c] && !rx_pop[c] && (o.rx_cnt >= o.rx_lim);
            s_d.ch[c].rx_wp = o.rx_wp + RX_AW'(rx_push[c]);
            s_d.ch[c].rx_rp = o.rx_rp + RX_AW'(rx_pop[c] | drop);
            s_d.ch[c].rx_cnt = o.rx_cnt + (RX_AW+1)'(rx_push[c] && !drop)
                               - (RX_AW+1)'(rx_pop[c]);
            if (drop) begin
                ev[c*EV_N + EV_OVF] = 1'b1;
            end
            if (s_d.ch[c].rx_cnt >= o.rx_thr && o.rx_cnt < o.rx_thr) begin
                ev[c*EV_N + EV_RXTHR] = 1'b1;
            end

            // open at once; close only after the tx queue has drained
            if (o.ctl[CTL_OPEN]) begin
                s_d.ch[c].active = 1'b1;
            end else if (o.active && o.tx_cnt == '0 && o.tx_st == LN_IDLE) begin
                s_d.ch[c].active = 1'b0;
                s_d.ch[c].rx_wp = '0;
                s_d.ch[c].rx_rp = '0;
                s_d.ch[c].rx_cnt = '0;
                s_d.ch[c].rx_st = LN_IDLE;
                clr[c*EV_N +: EV_N] = '1;
            end
        end

        // sticky events: a set in the clearing cycle survives
        s_d.irq_st = (s_q.irq_st & ~clr) | ev;
        s_d.irq = |(s_d.irq_st & s_d.irq_en);

        if (!aresetn) begin
            s_d = '0;
            for (int c = 0; c < NCH; c++) begin
                s_d.ch[c].div = DIV_RST;
                s_d.ch[c].rx_lim = RX_LIM_RST;
                s_d.ch[c].rx_thr = RX_THR_RST;
                s_d.ch[c].txd = 1'b1;
                s_d.ch[c].rx_sync = 2'h3;
            end
        end
    end

    always_ff @(posedge aclk) begin
        s_q <= s_d;
    end

    // ==========================================================
    // outputs
    assign awready = !s_q.aw_ok && !s_q.bvalid;
    assign wready = !s_q.w_ok && !s_q.bvalid;
    assign arready = !s_q.rvalid;
    assign bvalid = s_q.bvalid;
    assign bresp = s_q.bresp;
    assign rvalid = s_q.rvalid;
    assign rdata = s_q.rdata;
    assign rresp = s_q.rresp;
    assign irq = s_q.irq;
    assign first_serial_channel_tx = s_q.ch[0].txd;
    assign second_serial_channel_tx = s_q.ch[1].txd;
endmodule
`default_nettype wire

// *** tb/serial_partner.sv ***
// far-side serial device: drives the receive pin and samples the transmit pin
`default_nettype none
module serial_partner #(
    parameter int DIV = 271
) (
    input wire logic clk,
    input wire logic tx,
    output logic rx
);
    timeunit 1ns;
    timeprecision 1ps;
    logic idle = 1'b1;
    initial rx = 1'b1;
    // ==========================================================
    // line level follows the inversion option
    task automatic set_idle(input logic v);
        idle = v;
        rx <= v;
    endtask
    // ==========================================================
    // bit 0 is the start bit; the last bits are stops, so the line ends idle
    task automatic send(input logic [11:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            rx <= bits[i] ^ idle ^ 1'b1;
            repeat (DIV) @(posedge clk);
        end
    endtask
    task automatic recv(input int n, output logic [11:0] bits);
        bits = '1;
        while (tx === idle) @(posedge clk);
        repeat (DIV / 2) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            bits[i] = tx ^ idle ^ 1'b1;
            repeat (DIV) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// *** tb/dual_channel_async_serial_port_asserts.sv ***
// checker: bus handshake and serial line properties at the top ports
`default_nettype none
module serial_port_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic irq,
    input wire logic first_serial_channel_tx,
    input wire logic second_serial_channel_tx
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    bvalid_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    rvalid_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    read_block_a: assert property (rvalid |-> !arready)
        else $error("read address taken while busy");
    write_block_a: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
    read_answer_a: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    write_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write answer late");
    reset_idle_a: assert property ($rose(aresetn) |-> first_serial_channel_tx
        && second_serial_channel_tx && !irq && !bvalid)
        else $error("not idle after reset");
    // bench sends single frames and waits 10 cycles after an inversion edge, so every level lasts at least 8 cycles
    tx_min_bit_a: assert property ($changed(first_serial_channel_tx) |=>
        $stable(first_serial_channel_tx)[*7])
        else $error("transmit bit too short");
    cover property (bvalid && bresp == 2'h2);
    cover property ($rose(irq));
    cover property ($fell(first_serial_channel_tx));
endmodule
bind dual_channel_async_serial_port serial_port_chk u_chk (.aclk, .aresetn, .awvalid,
    .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata,
    .rvalid, .rready, .irq, .first_serial_channel_tx, .second_serial_channel_tx);
`default_nettype wire

// *** tb/dual_channel_async_serial_port_tb.sv ***
// testbench: register table, frame formats, receive path and events
`default_nettype none
module dual_channel_async_serial_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import serial_pkg::*;
    typedef struct packed {logic [7:0] a; logic [33:0] e;} row_t;
    row_t rows [8] = '{'{8'h00, 34'h0}, '{8'h04, 34'(DIV_RST)}, '{8'h08, 34'h10100},
        '{8'h0c, 34'h1000000}, '{8'h24, 34'(DIV_RST)}, '{8'h2c, 34'h1000000},
        '{8'h48, 34'h0}, '{8'h80, 34'h200000000}};
    logic [5:0] modes [4] = '{6'h01, 6'h0b, 6'h17, 6'h21};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, r;
    logic first_serial_channel_rx, first_serial_channel_tx, second_serial_channel_tx;
    logic second_serial_channel_rx = 1'b1;
    logic [11:0] ex, got;
    int n, cyc = 0, n_mismatch = 0, tests_run = 0;
    always #2 aclk = ~aclk;
    dual_channel_async_serial_port DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .irq, .first_serial_channel_rx, .first_serial_channel_tx,
        .second_serial_channel_rx, .second_serial_channel_tx);
    serial_partner #(.DIV(271)) p (.clk(aclk), .tx(first_serial_channel_tx),
        .rx(first_serial_channel_rx));
    // ==========================================================
    // helpers
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [33:0] s, input logic [33:0] e);
        tests_run++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            bready <= bvalid && !bready;
        end while (!(bvalid && bready));
        chk(34'(bresp), 34'(er));
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            rready <= rvalid && !rready;
        end while (!(rvalid && rready));
        v = rdata;
        rs = rresp;
    endtask
    // bit 0 start, data lsb first, parity, stops
    function automatic logic [11:0] frame(input logic [7:0] v, input logic [5:0] c,
            input logic bad, output int k);
        int nd;
        nd = c[CTL_SEVEN] ? 7 : 8;
        frame = 12'hffe;
        for (int i = 0; i < nd; i++)
            frame[i + 1] = v[i];
        if (c[CTL_PAR])
            frame[nd + 1] = (^(v & (c[CTL_SEVEN] ? 8'h7f : 8'hff))) ^ c[CTL_ODD] ^ bad;
        k = nd + 2 + int'(c[CTL_PAR]) + int'(c[CTL_TWO]);
    endfunction
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            n_mismatch++;
            end_sim();
        end
    end
    // ==========================================================
    // sequence
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 8; i++) begin
            rd(rows[i].a, d, r);
            chk({r, d}, rows[i].e);
        end
        wr(8'h04, 32'd271, RESP_OKAY);
        wr(OFS_IRQ_EN, 32'h1, RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, 32'h0, RESP_OKAY);
            repeat (10) @(posedge aclk);
            p.set_idle(~modes[i][CTL_INV]);
            wr(8'h00, 32'(modes[i]), RESP_OKAY);
            // let the inversion edge and the input synchroniser settle before a frame
            repeat (10) @(posedge aclk);
            ex = frame(8'hb1 + 8'(i), modes[i], 1'b0, n);
            fork
                wr(8'(OFS_TXD), 32'hb1 + 32'(i), RESP_OKAY);
                p.recv(n, got);
            join
            chk(34'(got), 34'(ex));
            p.send(ex, n);
            repeat (4) @(posedge aclk);
            if (i == 0)
                chk(34'(irq), 34'h1);
            rd(8'(OFS_RXD), d, r);
            chk(34'(d), 34'((8'hb1 + 8'(i)) & (modes[i][CTL_SEVEN] ? 8'h7f : 8'hff)));
        end
        wr(8'h00, 32'h0, RESP_OKAY);
        repeat (10) @(posedge aclk);
        p.set_idle(1'b1);
        wr(8'(OFS_RXCFG), 32'h1, RESP_OKAY);
        wr(8'h00, 32'h3, RESP_OKAY);
        wr(OFS_IRQ_EN, 32'h2, RESP_OKAY);
        repeat (10) @(posedge aclk);
        ex = frame(8'h3c, 6'h03, 1'b1, n);
        p.send(ex, n);
        ex = frame(8'h5a, 6'h03, 1'b0, n);
        p.send(ex, n);
        repeat (4) @(posedge aclk);
        chk(34'(irq), 34'h1);
        rd(8'(OFS_RXD), d, r);
        chk(34'(d), 34'h5a);
        wr(OFS_IRQ_EN, 32'h0, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk(34'(irq), 34'h0);
        wr(8'h30, 32'h55, RESP_SLVERR);
        chk(34'(second_serial_channel_tx), 34'h1);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h04, d, r);
        chk(34'(d), 34'(DIV_RST));
        end_sim();
    end
endmodule
`default_nettype wire
